// *** frc_reg_cmd.v ***
// frc_reg_cmd.v: register access command handler of a serial nor flash
// assumes: host drives chip select, serial clock and data lines; pe engine
// on ref_clk reports busy, suspend and error pulses
`timescale 1ns/100ps
`include "frc_reg_map.vh"
module frc_reg_cmd #(
   parameter SECTOR_BITS = 8,
   parameter [23:0] SW_CYCLES = (`FRC_STATUS_WRITE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS,
   parameter [23:0] NV_CYCLES = (`FRC_NV_CONFIG_WRITE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS
) (
   input wire ref_clk,
   input wire rst,
   input wire spi_clk,
   input wire chip_select_n,
   input wire [3:0] line_in,
   input wire write_protect_n,
   input wire [1:0] protocol_mode,
   input wire pe_busy,
   input wire erase_suspended,
   input wire err_erase,
   input wire err_program,
   input wire err_protect,
   input wire [SECTOR_BITS-1:0] pe_sector,
   output reg [3:0] line_out,
   output reg [3:0] line_oe,
   output reg write_in_progress,
   output reg write_enable_latch,
   output reg pe_write_locked,
   output reg [15:0] nv_config,
   output reg [7:0] v_config,
   output reg [7:0] ev_config
);

   localparam PH_IN = 2'd0;
   localparam PH_OUT = 2'd1;
   localparam PH_SKIP = 2'd2;
   localparam NSECT = 1 << SECTOR_BITS;

   wire [6:0] sync_lvl;
   wire [6:0] sync_rise;
   wire [3:0] line_s = sync_lvl[3:0];
   wire sclk_rise = sync_rise[4];
   wire cs_n_s = sync_lvl[5];
   wire cs_rise = sync_rise[5];
   wire wp_n_s = sync_lvl[6];
   wire tmr_busy;
   wire tmr_done;

   reg [1:0] phase;
   reg [6:0] total;
   reg [31:0] in_sr;
   reg [7:0] cmd;
   reg [15:0] out_sr;
   reg [4:0] out_cnt;
   reg nv_read;
   reg [SECTOR_BITS-1:0] rd_sector;
   reg [5:0] sr_hi;
   reg wel;
   reg fl_erase;
   reg fl_program;
   reg fl_protect;
   reg [5:0] pend_sr;
   reg [15:0] pend_nv;
   reg pend_is_nv;
   reg [1:0] lock_mem [0:NSECT-1];
   integer i;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and self-timed write counter

   frc_pin_sync #(.WIDTH(7), .IDLE(7'h60)) u_sync (  // select, protect idle high
      .ref_clk(ref_clk),
      .rst(rst),
      .pins({write_protect_n, chip_select_n, spi_clk, line_in}),
      .level(sync_lvl),
      .rise(sync_rise)
   );

   reg start_sw;
   reg start_nv;

   frc_op_timer #(.CW(24)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(start_sw | start_nv),
      .load(start_nv ? NV_CYCLES : SW_CYCLES),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // lane helpers

   function [4:0] lanes;
      input [1:0] m;
      begin
         case (m)
            `FRC_MODE_DUAL: lanes = 5'd2;
            `FRC_MODE_QUAD: lanes = 5'd4;
            default: lanes = 5'd1;
         endcase
      end
   endfunction

   // opcode and address come in on line 0, or on all active lanes
   function [31:0] shift_in;
      input [31:0] sr;
      input [3:0] d;
      input [1:0] m;
      begin
         case (m)
            `FRC_MODE_DUAL: shift_in = {sr[29:0], d[1:0]};
            `FRC_MODE_QUAD: shift_in = {sr[27:0], d};
            default: shift_in = {sr[30:0], d[0]};
         endcase
      end
   endfunction

   // extended answers on line 1 only
   function [3:0] pick;
      input [15:0] sr;
      input [1:0] m;
      begin
         case (m)
            `FRC_MODE_DUAL: pick = {2'b00, sr[15:14]};
            `FRC_MODE_QUAD: pick = sr[15:12];
            default: pick = {2'b00, sr[15], 1'b0};
         endcase
      end
   endfunction

   function [3:0] oe_mask;
      input [1:0] m;
      begin
         case (m)
            `FRC_MODE_DUAL: oe_mask = 4'h3;
            `FRC_MODE_QUAD: oe_mask = 4'hf;
            default: oe_mask = 4'h2;
         endcase
      end
   endfunction

   wire busy_all = tmr_busy | pe_busy;
   wire [7:0] status_byte = {sr_hi, wel, tmr_busy};
   wire [7:0] flag_byte = {~busy_all, erase_suspended, fl_erase, fl_program,
      2'b00, fl_protect, 1'b0};

   // byte answered by the single-byte reads, read live so polling tracks
   function [7:0] reg_byte;
      input [7:0] c;
      input [1:0] lk;
      begin
         case (c)
            `FRC_OP_RDSR: reg_byte = status_byte;
            `FRC_OP_RDFSR: reg_byte = flag_byte;
            `FRC_OP_RDVC: reg_byte = v_config;
            `FRC_OP_RDEV: reg_byte = ev_config;
            `FRC_OP_RDLOCK: reg_byte = {6'b000000, lk};
            default: reg_byte = 8'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next-value logic for the shifters

   wire [4:0] w = lanes(protocol_mode);
   wire in_edge = ~cs_n_s & sclk_rise & (phase == PH_IN);
   wire [31:0] next_in = shift_in(in_sr, line_s, protocol_mode);
   wire [6:0] next_total = (total < `FRC_BITS_SAT) ? total + {2'b00, w} : total;
   wire opc_done = in_edge & (next_total == `FRC_BITS_OPC);
   wire [7:0] opc = next_in[7:0];
   wire clr_fsr = opc_done & (opc == `FRC_OP_CLRFSR);
   wire lk_addr_done = in_edge & (cmd == `FRC_OP_RDLOCK) &
      (next_total == `FRC_BITS_ADDR);
   wire [SECTOR_BITS-1:0] addr_sector = next_in[23:24-SECTOR_BITS];
   wire [SECTOR_BITS-1:0] wr_sector = in_sr[31:32-SECTOR_BITS];

   reg is_read_opc;
   reg load_now;
   reg [15:0] out_src;
   reg [4:0] out_len;

   always @* begin
      case (opc)
         `FRC_OP_RDSR, `FRC_OP_RDFSR, `FRC_OP_RDNV,
         `FRC_OP_RDVC, `FRC_OP_RDEV: is_read_opc = 1'b1;
         default: is_read_opc = 1'b0;
      endcase
      // busy cycle keeps running, lock read just stays silent
      load_now = (opc_done & is_read_opc) | (lk_addr_done & ~busy_all);
      if (phase == PH_OUT) begin
         if (out_cnt == 5'd0) begin
            out_src = nv_read ? 16'h0000 : {reg_byte(cmd, lock_mem[rd_sector]), 8'h00};
            out_len = 5'd8;
         end else begin
            out_src = out_sr;
            out_len = out_cnt;
         end
      end else if (opc_done & (opc == `FRC_OP_RDNV)) begin
         out_src = nv_config | `FRC_NV_RSVD;
         out_len = 5'd16;
      end else if (opc_done) begin
         out_src = {reg_byte(opc, 2'b00), 8'h00};
         out_len = 5'd8;
      end else begin
         out_src = {reg_byte(`FRC_OP_RDLOCK, lock_mem[addr_sector]), 8'h00};
         out_len = 5'd8;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write acceptance at the select rising edge

   wire cnt_one = (total == `FRC_BITS_ONE);
   wire wr_ok = cs_rise & wel & ~busy_all;
   wire hw_prot = ~wp_n_s & sr_hi[`FRC_SR_PROT_BIT];
   wire vc_ok = wr_ok & cnt_one & (cmd == `FRC_OP_WRVC);
   wire ev_ok = wr_ok & cnt_one & (cmd == `FRC_OP_WREV);
   // suspended erase frees the array engine for lock changes
   wire lk_ok = cs_rise & wel & ~tmr_busy & (~pe_busy | erase_suspended) &
      (cmd == `FRC_OP_WRLOCK) & (total == `FRC_BITS_LOCKW);

   always @* begin
      start_sw = wr_ok & cnt_one & (cmd == `FRC_OP_WRSR) & ~hw_prot;
      start_nv = wr_ok & (cmd == `FRC_OP_WRNV) & (total == `FRC_BITS_TWO);
   end

   ////////////////////////////////////////////////////////////////////////
   // link, register and lock state

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase <= PH_IN;
         total <= 7'd0;
         in_sr <= 32'h00000000;
         cmd <= 8'h00;
         out_sr <= 16'h0000;
         out_cnt <= 5'd0;
         nv_read <= 1'b0;
         rd_sector <= {SECTOR_BITS{1'b0}};
         line_out <= 4'h0;
         line_oe <= 4'h0;
         sr_hi <= `FRC_SR_RESET;
         wel <= 1'b0;
         fl_erase <= 1'b0;
         fl_program <= 1'b0;
         fl_protect <= 1'b0;
         pend_sr <= `FRC_SR_RESET;
         pend_nv <= `FRC_NV_RESET;
         pend_is_nv <= 1'b0;
         nv_config <= `FRC_NV_RESET;
         v_config <= `FRC_VC_RESET;
         ev_config <= `FRC_EV_RESET;
         write_in_progress <= 1'b0;
         write_enable_latch <= 1'b0;
         pe_write_locked <= 1'b0;
         for (i = 0; i < NSECT; i = i + 1) begin
            lock_mem[i] <= 2'b00;
         end
      end else begin
         // a new error pulse beats a clear in the same cycle
         fl_erase <= (fl_erase & ~clr_fsr) | err_erase;
         fl_program <= (fl_program & ~clr_fsr) | err_program;
         fl_protect <= (fl_protect & ~clr_fsr) | err_protect;
         if (cs_n_s) begin
            phase <= PH_IN;
            total <= 7'd0;
            line_oe <= 4'h0;
         end else if (sclk_rise) begin
            if (phase == PH_IN) begin
               in_sr <= next_in;
               total <= next_total;
            end
            if (opc_done) begin
               cmd <= opc;
               nv_read <= (opc == `FRC_OP_RDNV);
               if (opc == `FRC_OP_WREN && !tmr_busy) begin
                  wel <= 1'b1;
               end
               if (opc == `FRC_OP_WRDI && !tmr_busy) begin
                  wel <= 1'b0;
               end
            end
            if (lk_addr_done) begin
               rd_sector <= addr_sector;
               if (busy_all) begin
                  phase <= PH_SKIP;
               end
            end
            // data moves out right after the sampling edge, one edge ahead
            if (load_now || phase == PH_OUT) begin
               phase <= PH_OUT;
               line_out <= pick(out_src, protocol_mode);
               out_sr <= out_src << w;
               out_cnt <= out_len - w;
               line_oe <= oe_mask(protocol_mode);
            end
         end
         if (start_sw) begin
            pend_sr <= in_sr[7:2];
            pend_is_nv <= 1'b0;
         end
         if (start_nv) begin
            pend_nv <= {in_sr[7:0], in_sr[15:8]};
            pend_is_nv <= 1'b1;
         end
         if (tmr_done) begin
            if (pend_is_nv) begin
               nv_config <= pend_nv;
            end else begin
               sr_hi <= pend_sr;
            end
            wel <= 1'b0;
         end
         if (vc_ok) begin
            v_config <= (in_sr[7:0] & ~`FRC_VC_RSVD) | (v_config & `FRC_VC_RSVD);
            wel <= 1'b0;
         end
         if (ev_ok) begin
            ev_config <= (in_sr[7:0] & ~`FRC_EV_RSVD) | (ev_config & `FRC_EV_RSVD);
            wel <= 1'b0;
         end
         if (lk_ok) begin
            if (!lock_mem[wr_sector][`FRC_LK_DOWN]) begin
               lock_mem[wr_sector] <= in_sr[1:0];
            end
            wel <= 1'b0;
         end
         write_in_progress <= tmr_busy | start_sw | start_nv;
         write_enable_latch <= wel;
         pe_write_locked <= lock_mem[pe_sector][`FRC_LK_WLOCK];
      end
   end

endmodule // frc_reg_cmd

// *** frc_reg_map.vh ***
// frc_reg_map.vh: opcodes, field positions, reset values and timing figures
// assumes: included by the register command block and the testbench
`ifndef FRC_REG_MAP_VH
`define FRC_REG_MAP_VH

// command opcodes
`define FRC_OP_WREN 8'h06
`define FRC_OP_WRDI 8'h04
`define FRC_OP_RDSR 8'h05
`define FRC_OP_WRSR 8'h01
`define FRC_OP_RDLOCK 8'he8
`define FRC_OP_WRLOCK 8'he5
`define FRC_OP_RDFSR 8'h70
`define FRC_OP_CLRFSR 8'h50
`define FRC_OP_RDNV 8'hb5
`define FRC_OP_WRNV 8'hb1
`define FRC_OP_RDVC 8'h85
`define FRC_OP_WRVC 8'h81
`define FRC_OP_RDEV 8'h65
`define FRC_OP_WREV 8'h61

// protocol select codes
`define FRC_MODE_EXT 2'd0
`define FRC_MODE_DUAL 2'd1
`define FRC_MODE_QUAD 2'd2

// bit counts seen on the link, opcode included
`define FRC_BITS_OPC 7'd8
`define FRC_BITS_ONE 7'd16
`define FRC_BITS_TWO 7'd24
`define FRC_BITS_ADDR 7'd32
`define FRC_BITS_LOCKW 7'd40
`define FRC_BITS_SAT 7'd120

// field positions
`define FRC_SR_PROT_BIT 5
`define FRC_LK_DOWN 1
`define FRC_LK_WLOCK 0

// reset values and reserved masks
`define FRC_SR_RESET 6'h00
`define FRC_NV_RESET 16'hffff
`define FRC_NV_RSVD 16'h0010
`define FRC_VC_RESET 8'hfb
`define FRC_VC_RSVD 8'h04
`define FRC_EV_RESET 8'hdf
`define FRC_EV_RSVD 8'h10

// timing figures in ns
`define FRC_CLK_NS 50
`define FRC_STATUS_WRITE_NS 1000000
`define FRC_NV_CONFIG_WRITE_NS 2000000
`define FRC_LATCH_CLEAR_NS 50

`endif

// *** frc_pin_sync.v ***
// frc_pin_sync.v: two-flop synchroniser with edge detection for link pins
// assumes: pins come from outside the ref_clk domain
`timescale 1ns/100ps
module frc_pin_sync #(
   parameter WIDTH = 7,
   // reset to the pins' idle levels so no false edge follows reset
   parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
   input wire ref_clk,
   input wire rst,
   input wire [WIDTH-1:0] pins,
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;
   reg [WIDTH-1:0] prev;

   ////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta <= IDLE;
         stable <= IDLE;
         prev <= IDLE;
      end else begin
         meta <= pins;
         stable <= meta;
         prev <= stable;
      end
   end

   assign level = stable;
   assign rise = stable & ~prev;

endmodule // frc_pin_sync

// *** frc_op_timer.v ***
// frc_op_timer.v: down counter timing a self-timed register write
// assumes: start is a one-cycle pulse on ref_clk, load at least 1
`timescale 1ns/100ps
module frc_op_timer #(
   parameter CW = 24
) (
   input wire ref_clk,
   input wire rst,
   input wire start,
   input wire [CW-1:0] load,
   output reg busy,
   output reg done
);

   reg [CW-1:0] count;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count <= {CW{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= load;
            busy <= 1'b1;
         end else if (busy) begin
            if (count <= {{(CW-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // frc_op_timer

// *** frc_reg_cmd_chk.sv ***
// frc_reg_cmd_chk.sv: port-level assertions for the register command block
// assumes: bound to frc_reg_cmd, one ref_clk domain, rst active high
`timescale 1ns/100ps
module frc_reg_cmd_chk #(
   parameter SW_CYCLES = 200,
   parameter NV_CYCLES = 300
) (
   input wire ref_clk,
   input wire rst,
   input wire chip_select_n,
   input wire [1:0] protocol_mode,
   input wire [3:0] line_oe,
   input wire write_in_progress,
   input wire write_enable_latch,
   input wire [15:0] nv_config,
   input wire [7:0] v_config,
   input wire [7:0] ev_config
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // length of the current busy stretch
   reg [15:0] wcnt;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) wcnt <= 16'h0000;
      else if (write_in_progress) wcnt <= wcnt + 16'h0001;
      else wcnt <= 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_oe_ext;
      (protocol_mode == 2'd0) && (line_oe != 4'h0) |-> line_oe == 4'h2;
   endproperty
   a_oe_ext: assert property (p_oe_ext) else $error("ext drive not on line 1");
   property p_oe_quad;
      (protocol_mode == 2'd2) && (line_oe != 4'h0) |-> line_oe == 4'hf;
   endproperty
   a_oe_quad: assert property (p_oe_quad) else $error("quad drive not on 4 lines");
   property p_oe_dual;
      (protocol_mode == 2'd1) && (line_oe != 4'h0) |-> line_oe == 4'h3;
   endproperty
   a_oe_dual: assert property (p_oe_dual) else $error("dual drive not on 2 lines");
   property p_cs_stop;
      $rose(chip_select_n) |-> ##[1:6] (line_oe == 4'h0);
   endproperty
   a_cs_stop: assert property (p_cs_stop) else $error("drive kept after select");
   property p_wip_sel;
      $rose(write_in_progress) |-> chip_select_n;
   endproperty
   a_wip_sel: assert property (p_wip_sel) else $error("write began inside frame");
   // one cycle of slack either way for the sync path
   property p_wip_len;
      $fell(write_in_progress) |->
         (wcnt >= SW_CYCLES - 1 && wcnt <= SW_CYCLES + 1) ||
         (wcnt >= NV_CYCLES - 1 && wcnt <= NV_CYCLES + 1);
   endproperty
   a_wip_len: assert property (p_wip_len) else $error("busy length wrong");
   property p_wel_clr;
      $fell(write_in_progress) |-> ##[0:2] !write_enable_latch;
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("latch left after write");
   property p_vc_wel;
      $changed(v_config) || $changed(ev_config) |-> $past(write_enable_latch);
   endproperty
   a_vc_wel: assert property (p_vc_wel) else $error("config changed without latch");
   property p_vc_rsvd;
      $changed(v_config) || $changed(ev_config) |->
         v_config[2] == $past(v_config[2]) && ev_config[4] == $past(ev_config[4]);
   endproperty
   a_vc_rsvd: assert property (p_vc_rsvd) else $error("reserved config bit moved");
   property p_nv_wip;
      $changed(nv_config) |-> $past(write_in_progress) || $past(write_in_progress, 2);
   endproperty
   a_nv_wip: assert property (p_nv_wip) else $error("nv changed outside write");
endmodule // frc_reg_cmd_chk

bind frc_reg_cmd frc_reg_cmd_chk #(.SW_CYCLES(SW_CYCLES), .NV_CYCLES(NV_CYCLES)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
   .protocol_mode(protocol_mode), .line_oe(line_oe),
   .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
   .nv_config(nv_config), .v_config(v_config), .ev_config(ev_config));

// *** frc_host_model.sv ***
// frc_host_model.sv: behavioural host controller driving frames on the link
// assumes: spi clock 400 ns, idle low between frames; lines resolved here
`timescale 1ns/100ps
module frc_host_model (
   input wire ref_clk,
   input wire [3:0] line_out,
   input wire [3:0] line_oe,
   output reg spi_clk,
   output reg chip_select_n,
   output wire [3:0] line_in
);
   reg [3:0] hd;
   reg saw_oe;
   // undriven lines toggle so a stale value never looks valid
   assign line_in = (line_oe & line_out) | (~line_oe & hd);
   initial begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      hd = 4'h5;
      saw_oe = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (!chip_select_n && line_oe != 4'h0) saw_oe <= 1'b1;
   end
   // msb-first, bpc lines per edge, no dummy cycles
   task xfer(input integer bpc, input [47:0] wd, input integer nw, input integer nr,
      output [23:0] rd);
      integer i, b;
      begin
         rd = 24'h000000;
         saw_oe = 1'b0;
         chip_select_n = 1'b0;
         for (i = 0; i < (nw + nr) / bpc; i = i + 1) begin
            hd = ~hd;
            if (i * bpc < nw) begin
               for (b = 0; b < bpc; b = b + 1) hd[bpc - 1 - b] = wd[47 - b];
               wd = wd << bpc;
            end
            #200 spi_clk = 1'b1;
            if (i * bpc >= nw) begin
               if (bpc == 1) rd = {rd[22:0], line_in[1]};
               else for (b = 0; b < bpc; b = b + 1) rd = {rd[22:0], line_in[bpc - 1 - b]};
            end
            #200 spi_clk = 1'b0;
         end
         #100 chip_select_n = 1'b1;
         hd = ~hd;
         #400;
      end
   endtask
endmodule // frc_host_model

// *** testbench.sv ***
// testbench.sv: directed scenarios for the register command block
// assumes: host model drives the link, bench drives engine status pins
`timescale 1ns/100ps
`include "frc_reg_map.vh"
module testbench;
   reg ref_clk, rst, write_protect_n, pe_busy, erase_suspended;
   reg err_erase, err_program, err_protect;
   reg [1:0] protocol_mode;
   reg [7:0] pe_sector;
   wire spi_clk, chip_select_n, write_in_progress, write_enable_latch, pe_write_locked;
   wire [3:0] line_in, line_out, line_oe;
   wire [15:0] nv_config;
   wire [7:0] v_config, ev_config;
   reg [23:0] rd;
   integer err_total, n_checks, k;
   frc_reg_cmd #(.SW_CYCLES(24'd200), .NV_CYCLES(24'd300)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .spi_clk(spi_clk), .chip_select_n(chip_select_n),
      .line_in(line_in), .write_protect_n(write_protect_n), .protocol_mode(protocol_mode),
      .pe_busy(pe_busy), .erase_suspended(erase_suspended), .err_erase(err_erase),
      .err_program(err_program), .err_protect(err_protect), .pe_sector(pe_sector),
      .line_out(line_out), .line_oe(line_oe), .write_in_progress(write_in_progress),
      .write_enable_latch(write_enable_latch), .pe_write_locked(pe_write_locked),
      .nv_config(nv_config), .v_config(v_config), .ev_config(ev_config));
   frc_host_model host_u (.ref_clk(ref_clk), .line_out(line_out), .line_oe(line_oe),
      .spi_clk(spi_clk), .chip_select_n(chip_select_n), .line_in(line_in));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [23:0] seen, input [23:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tick;
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task op(input [7:0] c, input integer nr);
      host_u.xfer(1, {c, 40'h0}, 8, nr, rd);
   endtask
   task lkw(input [7:0] s, input [7:0] d);
      begin
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRLOCK, s, 16'h0000, d, 8'h00}, 40, 0, rd);
      end
   endtask
   task lkr(input [7:0] s);
      host_u.xfer(1, {`FRC_OP_RDLOCK, s, 16'h0000, 16'h0000}, 32, 16, rd);
   endtask
   // host polls busy before the next command
   task wait_wip;
      begin
         for (k = 0; k < 400 && write_in_progress !== 1'b0; k = k + 1) tick;
         chk("wip_end", write_in_progress, 24'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         chk("nv_rst", nv_config, `FRC_NV_RESET);
         chk("vc_rst", v_config, `FRC_VC_RESET);
         chk("ev_rst", ev_config, `FRC_EV_RESET);
         chk("wel_rst", write_enable_latch, 24'h0);
      end
   endtask
   task t_status;
      begin
         host_u.xfer(1, {`FRC_OP_WRSR, 8'hfc, 32'h0}, 16, 0, rd);
         chk("wip_nolatch", write_in_progress, 24'h0);
         op(`FRC_OP_WREN, 0);
         chk("wel_set", write_enable_latch, 24'h1);
         host_u.xfer(1, {`FRC_OP_WRSR, 8'h5f, 32'h0}, 16, 0, rd);
         chk("wip_on", write_in_progress, 24'h1);
         op(`FRC_OP_RDSR, 8);
         chk("sr_busy_bit", rd[0], 24'h1);
         wait_wip;
         op(`FRC_OP_RDSR, 16);
         chk("sr_after", rd[15:0], 24'h5c5c);
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRSR, 8'h80, 32'h0}, 16, 0, rd);
         wait_wip;
         write_protect_n = 1'b0;
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRSR, 8'h00, 32'h0}, 16, 0, rd);
         chk("wip_hwprot", write_in_progress, 24'h0);
         op(`FRC_OP_RDSR, 8);
         chk("sr_hwprot", rd[7:0], 24'h82);
         write_protect_n = 1'b1;
         op(`FRC_OP_WRDI, 0);
      end
   endtask
   task t_nv;
      begin
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRNV, 8'ha5, 8'h12, 24'h0}, 24, 0, rd);
         wait_wip;
         op(`FRC_OP_RDNV, 24);
         chk("nv_read", rd, {16'h12a5 | `FRC_NV_RSVD, 8'h00});
      end
   endtask
   task t_vc;
      begin
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRVC, 8'h0f, 32'h0}, 16, 0, rd);
         chk("vc_wr", v_config, (8'h0f & ~`FRC_VC_RSVD) | (`FRC_VC_RESET & `FRC_VC_RSVD));
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WREV, 8'h00, 32'h0}, 16, 0, rd);
         chk("ev_wr", ev_config, `FRC_EV_RESET & `FRC_EV_RSVD);
         op(`FRC_OP_RDVC, 16);
         chk("vc_repeat", rd[15:0], 24'h0b0b);
         op(`FRC_OP_WREN, 0);
         host_u.xfer(1, {`FRC_OP_WRVC, 8'hf0, 32'h0}, 12, 0, rd);
         chk("vc_short", v_config, 24'h0b);
         chk("wel_kept", write_enable_latch, 24'h1);
         op(8'hff, 0);
         chk("wel_unknown", write_enable_latch, 24'h1);
         op(`FRC_OP_WRDI, 0);
         chk("wel_off", write_enable_latch, 24'h0);
      end
   endtask
   task t_lock;
      begin
         lkw(8'h07, 8'h01);
         chk("wel_lock", write_enable_latch, 24'h0);
         pe_sector = 8'h07;
         repeat (3) tick;
         chk("wlock_pe", pe_write_locked, 24'h1);
         pe_sector = 8'h08;
         repeat (3) tick;
         chk("wlock_free", pe_write_locked, 24'h0);
         lkr(8'h07);
         chk("lock_rd", rd[15:0], 24'h0101);
         lkw(8'h07, 8'h03);
         lkw(8'h07, 8'h00);
         lkr(8'h07);
         chk("lockdown", rd[15:0], 24'h0303);
         pe_busy = 1'b1;
         lkr(8'h07);
         chk("lock_busy_oe", host_u.saw_oe, 24'h0);
         erase_suspended = 1'b1;
         lkw(8'h09, 8'h01);
         chk("wel_susp", write_enable_latch, 24'h0);
         pe_busy = 1'b0;
         lkr(8'h09);
         chk("lock_susp", rd[15:0], 24'h0101);
         erase_suspended = 1'b0;
      end
   endtask
   task t_flag;
      begin
         tick;
         err_erase = 1'b1;
         err_protect = 1'b1;
         tick;
         err_erase = 1'b0;
         err_protect = 1'b0;
         op(`FRC_OP_RDFSR, 8);
         chk("fsr_err", rd[7:0], 24'ha2);
         pe_busy = 1'b1;
         op(`FRC_OP_RDFSR, 8);
         chk("fsr_busy", rd[7:0], 24'h22);
         pe_busy = 1'b0;
         op(`FRC_OP_CLRFSR, 0);
         op(`FRC_OP_RDFSR, 8);
         chk("fsr_clr", rd[7:0], 24'h80);
      end
   endtask
   task t_quad;
      begin
         protocol_mode = `FRC_MODE_QUAD;
         host_u.xfer(4, {`FRC_OP_RDVC, 40'h0}, 8, 8, rd);
         chk("quad_vc", rd[7:0], 24'h0b);
         protocol_mode = `FRC_MODE_DUAL;
         host_u.xfer(2, {`FRC_OP_RDEV, 40'h0}, 8, 16, rd);
         chk("dual_ev", rd[15:0], 24'h1010);
         protocol_mode = `FRC_MODE_EXT;
         op(`FRC_OP_RDSR, 4);
         chk("abort_oe", line_oe, 24'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      n_checks = 0;
      rst = 1'b1;
      write_protect_n = 1'b1;
      pe_busy = 1'b0;
      erase_suspended = 1'b0;
      err_erase = 1'b0;
      err_program = 1'b0;
      err_protect = 1'b0;
      protocol_mode = `FRC_MODE_EXT;
      pe_sector = 8'h00;
      repeat (8) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (4) tick;
      t_reset;
      t_status;
      t_nv;
      t_vc;
      t_lock;
      t_flag;
      t_quad;
      end_sim;
   end
   // whole sequence needs about 0.4 ms of link time
   initial begin
      #3000000;
      err_total = err_total + 1;
      end_sim;
   end
endmodule // testbench
